// *** core/utx_pkg.sv ***
/*
  utx_pkg: constants for the transmit path of an asynchronous serial port.
  Assumes the host side presents programmed register values as plain levels
  and a one-cycle write strobe for the holding register.
*/
// Functional notes
// - bit lasts 16, 8 or 4 samples
// - start, data, optional parity, then stop bits
// - data goes out least significant bit first
// - 8-bit shifter fed by 64-byte fifo
// - fifo enable routes holding writes into fifo
// - each accepted holding write bumps write pointer
// - non-fifo: empty flag set on shifter load
// - tx-empty interrupt only when enable bit set
// - shifter-empty flag once shifter fully drained
// - divisor integer bytes plus sixteenths fraction
// - fraction bits 5:4 pick 16x/8x/4x
// - modem control bit 7 prescales by 4
// - fifo mode: empty flag while fifo empty
package utx_pkg;
  localparam int unsigned FIFO_DEPTH     = 64;  // transmit fifo entries
  localparam int unsigned DATA_W         = 8;   // shift register width
  // register bit positions
  localparam int unsigned FIFO_EN_BIT     = 0;
  localparam int unsigned HOLD_EMPTY_BIT  = 5;
  localparam int unsigned SHIFT_EMPTY_BIT = 6;
  localparam int unsigned IRQ_TX_EMPTY_BIT = 1;
  localparam int unsigned IRQ_EN_TX_BIT   = 1;
  localparam int unsigned PRESCALE_BIT    = 7;
  localparam int unsigned FRAC_LSB       = 0;   // fraction field [3:0]
  localparam int unsigned MODE_LSB       = 4;   // sampling mode field [5:4]
  localparam int unsigned LCR_LEN_LSB    = 0;   // word length [1:0]
  localparam int unsigned LCR_STOP2      = 2;
  localparam int unsigned LCR_PAR_EN     = 3;
  localparam int unsigned LCR_PAR_EVEN   = 4;
  // sampling modes
  localparam logic [1:0]  MODE_16X       = 2'h0;
  localparam logic [1:0]  MODE_8X        = 2'h1;
  localparam logic [1:0]  MODE_4X        = 2'h2;
  localparam logic [4:0]  SAMP_16X       = 5'h10;
  localparam logic [4:0]  SAMP_8X        = 5'h08;
  localparam logic [4:0]  SAMP_4X        = 5'h04;
  // prescaler
  localparam logic [1:0]  PRESCALE_LAST  = 2'h3;  // divide by 4
  // divisor in sixteenths, one prescaled clock step
  localparam logic [20:0] ACC_STEP       = 21'h00010;
  localparam logic [19:0] DIV_ONE        = 20'h00010;  // divisor of 1
  // reset values of the status outputs
  localparam logic [7:0]  STATUS_RESET   = 8'h60;
  localparam logic [7:0]  IRQ_RESET      = 8'h00;

  // transmitter sequence, gray coded from idle through parity to stop
  typedef enum logic [2:0] {
    UTX_IDLE   = 3'h0,
    UTX_LOAD   = 3'h1,
    UTX_START  = 3'h3,
    UTX_DATA   = 3'h2,
    UTX_PARITY = 3'h6,
    UTX_STOP   = 3'h7
  } utx_state_e;
endpackage : utx_pkg

// *** core/utx_mem.sv ***
/*
  utx_mem: small dual-port buffer for the transmit fifo.
  Assumes one writer and one reader on the same clock; read data is
  registered, so it trails the read address by one edge.
*/
`timescale 1ns/1ps
module utx_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH];  // no reset: contents are don't-care

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end
endmodule : utx_mem

// *** core/utx_top.sv ***
/*
  utx_top: transmit half of a serial port with holding register, 64-byte
  fifo, 8-bit shifter, fractional baud divisor and transmit status.
  Assumes register contents arrive as steady levels from the host interface
  logic and holding-register writes come as one-cycle strobes on clk.
*/
`timescale 1ns/1ps
module utx_top
  import utx_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned AW    = $clog2(FIFO_DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hold_wr,            // write strobe, holding register
  input  wire logic [7:0]  tx_holding_reg,     // byte written with hold_wr
  input  wire logic [7:0]  fifo_control_reg,
  input  wire logic [7:0]  irq_enable_reg,
  input  wire logic [7:0]  line_control_reg,
  input  wire logic [7:0]  modem_control_reg,
  input  wire logic [7:0]  baud_divisor_low,
  input  wire logic [7:0]  baud_divisor_high,
  input  wire logic [7:0]  baud_fraction_reg,
  output logic             tx_out,             // serial line, idles high
  output logic [7:0]       line_status_reg,
  output logic [7:0]       irq_status_reg,
  output logic             irq_n,              // active low interrupt
  output logic [AW:0]      tx_level            // bytes waiting
);

  // samples per bit for a sampling mode
  function automatic logic [4:0] bit_len(input logic [1:0] mode);
    case (mode)
      MODE_8X: bit_len = SAMP_8X;
      MODE_4X: bit_len = SAMP_4X;
      default: bit_len = SAMP_16X;
    endcase
  endfunction : bit_len

  // data bits per character, 5 to 8
  function automatic logic [3:0] word_bits(input logic [1:0] len);
    word_bits = 4'h5 + {2'h0, len};
  endfunction : word_bits

  logic [7:0]  mem_rdata;              // head of fifo, registered
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;   // fifo write pointer
  logic [AW-1:0] rd_ptr_q, rd_ptr_d;   // fifo read pointer
  logic [AW:0] cnt_q, cnt_d;           // fifo occupancy
  logic        fifo_en;                // fifo operation selected
  logic        full;                   // no room for another byte
  logic        push;                   // accepted holding write
  logic        pop;                    // head moved into shifter

  logic [1:0]  pre_q, pre_d;           // prescaler count
  logic        pre_tick;               // prescaled clock step
  logic [20:0] acc_q, acc_d;           // fractional divider, sixteenths
  logic [19:0] divisor;                // integer and fraction, sixteenths
  logic        samp_tick;              // one sampling clock period

  utx_state_e  st_q, st_d;             // transmit sequence
  logic [7:0]  shift_q, shift_d;       // transmit shift register
  logic [4:0]  samp_q, samp_d;         // samples into current bit
  logic [3:0]  bit_q, bit_d;           // data or stop bits sent
  logic        par_q, par_d;           // running parity of data bits
  logic        bit_done;               // current bit time elapsed
  logic        line_d;                 // next serial level
  logic [7:0]  status_d, irq_d;        // next status values
  logic        hold_empty;             // holding register or fifo empty

  assign fifo_en = fifo_control_reg[FIFO_EN_BIT];
  // non-fifo mode keeps a single holding byte
  assign full = fifo_en ? (cnt_q == (AW+1)'(DEPTH)) : (cnt_q != '0);
  assign push = hold_wr && !full;
  assign pop  = (st_q == UTX_LOAD);

  // 64-byte store ahead of the shifter
  utx_mem #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_q),
    .wr_data (tx_holding_reg),
    .rd_addr (rd_ptr_q),
    .rd_data (mem_rdata)
  );

  // fifo pointers and occupancy
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d    = cnt_q;
    if (push) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 1'b1;
    end
    case ({push, pop})
      2'b10:   cnt_d = cnt_q + 1'b1;
      2'b01:   cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  // divisor from integer bytes and fraction nibble
  always_comb begin
    divisor = {baud_divisor_high, baud_divisor_low, baud_fraction_reg[FRAC_LSB +: 4]};
    // an integer part of zero would tick every step and leave the accumulator growing; treat it as one
    if (divisor < DIV_ONE) begin
      divisor = DIV_ONE;
    end
  end

  // prescaler, divide by 1 or 4
  assign pre_tick = !modem_control_reg[PRESCALE_BIT] || (pre_q == PRESCALE_LAST);
  // fractional divider: add one clock, subtract divisor on overflow
  assign samp_tick = pre_tick && ((acc_q + ACC_STEP) >= {1'b0, divisor});

  always_comb begin
    pre_d = modem_control_reg[PRESCALE_BIT] ? pre_q + 1'b1 : '0;
    acc_d = acc_q;
    if (samp_tick) begin
      acc_d = acc_q + ACC_STEP - {1'b0, divisor};
    end else if (pre_tick) begin
      acc_d = acc_q + ACC_STEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= '0;
      acc_q <= '0;
    end else begin
      pre_q <= pre_d;
      acc_q <= acc_d;
    end
  end

  // bit time counted in sampling periods
  assign bit_done = samp_tick && (samp_q == bit_len(baud_fraction_reg[MODE_LSB +: 2]) - 5'h01);

  // transmit sequence and shifter
  always_comb begin
    st_d    = st_q;
    shift_d = shift_q;
    samp_d  = samp_q;
    bit_d   = bit_q;
    par_d   = par_q;
    line_d  = 1'b1;
    if (samp_tick) begin
      samp_d = bit_done ? 5'h00 : samp_q + 5'h01;
    end
    case (st_q)
      UTX_IDLE: begin
        // head byte is readable one edge after it is written
        if (cnt_q != '0) begin
          st_d = UTX_LOAD;
        end
      end
      UTX_LOAD: begin
        shift_d = mem_rdata;
        samp_d  = 5'h00;
        bit_d   = 4'h0;
        // odd parity starts at one, even at zero
        par_d   = !line_control_reg[LCR_PAR_EVEN];
        st_d    = UTX_START;
      end
      UTX_START: begin
        line_d = 1'b0;
        if (bit_done) begin
          st_d = UTX_DATA;
        end
      end
      UTX_DATA: begin
        line_d = shift_q[0];
        if (bit_done) begin
          shift_d = {1'b0, shift_q[7:1]};
          par_d   = par_q ^ shift_q[0];
          bit_d   = bit_q + 4'h1;
          if (bit_q == word_bits(line_control_reg[LCR_LEN_LSB +: 2]) - 4'h1) begin
            bit_d = 4'h0;
            st_d  = line_control_reg[LCR_PAR_EN] ? UTX_PARITY : UTX_STOP;
          end
        end
      end
      UTX_PARITY: begin
        line_d = par_q;
        if (bit_done) begin
          st_d = UTX_STOP;
        end
      end
      UTX_STOP: begin
        line_d = 1'b1;
        if (bit_done) begin
          bit_d = bit_q + 4'h1;
          if (!line_control_reg[LCR_STOP2] || bit_q != 4'h0) begin
            st_d = UTX_IDLE;
          end
        end
      end
      default: st_d = UTX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= UTX_IDLE;
      shift_q <= '0;
      samp_q  <= '0;
      bit_q   <= '0;
      par_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      shift_q <= shift_d;
      samp_q  <= samp_d;
      bit_q   <= bit_d;
      par_q   <= par_d;
    end
  end

  // empty once the last byte has left for the shifter
  assign hold_empty = (cnt_d == '0);

  // status and interrupt, computed from next state so outputs stay in step
  always_comb begin
    status_d = '0;
    irq_d    = '0;
    status_d[HOLD_EMPTY_BIT] = hold_empty;
    status_d[SHIFT_EMPTY_BIT] = hold_empty && (st_d == UTX_IDLE);
    irq_d[IRQ_TX_EMPTY_BIT] = hold_empty && irq_enable_reg[IRQ_EN_TX_BIT];
  end

  // registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_out          <= 1'b1;
      line_status_reg <= STATUS_RESET;
      irq_status_reg  <= IRQ_RESET;
      irq_n           <= 1'b1;
      tx_level        <= '0;
    end else begin
      tx_out          <= line_d;
      line_status_reg <= status_d;
      irq_status_reg  <= irq_d;
      irq_n           <= !irq_d[IRQ_TX_EMPTY_BIT];
      tx_level        <= cnt_d;
    end
  end
endmodule : utx_top

// *** dv/utx_props.sv ***
/*
  utx_props: port checks for utx_top.
  Assumes rate settings change only while the line is idle.
*/
`timescale 1ns/1ps
module utx_props
  import utx_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned AW    = $clog2(FIFO_DEPTH)
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hold_wr,
  input wire logic [7:0]  fifo_control_reg,
  input wire logic [7:0]  irq_enable_reg,
  input wire logic [7:0]  modem_control_reg,
  input wire logic [7:0]  baud_divisor_low,
  input wire logic [7:0]  baud_divisor_high,
  input wire logic [7:0]  baud_fraction_reg,
  input wire logic        tx_out,
  input wire logic [7:0]  line_status_reg,
  input wire logic [7:0]  irq_status_reg,
  input wire logic        irq_n,
  input wire logic [AW:0] tx_level
);
  logic [11:0] low_q, low_d; // cycles the line sat low
  logic [4:0]  n;            // samples per bit
  logic        one;          // unit divisor, no prescale
  // low run length
  always_comb begin
    low_d = tx_out ? 12'h000 : low_q + 12'h001;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_q <= 12'h000;
    else low_q <= low_d;
  end
  assign n = baud_fraction_reg[5:4] == MODE_8X ? SAMP_8X :
             baud_fraction_reg[5:4] == MODE_4X ? SAMP_4X : SAMP_16X;
  // here a bit lasts exactly n clocks
  assign one = {baud_divisor_high, baud_divisor_low, baud_fraction_reg[3:0]} == DIV_ONE
               && !modem_control_reg[PRESCALE_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // lone write into an idle path
  sequence s_wr_idle;
    hold_wr && tx_level == 0 && line_status_reg[SHIFT_EMPTY_BIT] ##1 !hold_wr [*2];
  endsequence
  // shifter load, then start bit
  sequence s_load_start;
    tx_level == 1 ##1 line_status_reg[HOLD_EMPTY_BIT] && tx_level == 0 ##1 !tx_out;
  endsequence
  a_idle_line: assert property (
    line_status_reg[SHIFT_EMPTY_BIT] |-> tx_out && tx_level == 0)
    else $error("line busy while shifter empty");
  a_hold_flag: assert property (
    line_status_reg[HOLD_EMPTY_BIT] == (tx_level == 0))
    else $error("holding flag disagrees with level");
  a_status_spare: assert property (
    (line_status_reg & 8'h9f) == 8'h00)
    else $error("spare status bits set");
  a_irq_follow: assert property (
    $past(reset_n) |-> irq_status_reg == {6'h00, line_status_reg[HOLD_EMPTY_BIT]
      && $past(irq_enable_reg[IRQ_EN_TX_BIT]), 1'b0} && irq_n == !irq_status_reg[1])
    else $error("interrupt not tied to empty and enable");
  a_no_rise: assert property (
    !hold_wr |=> tx_level <= $past(tx_level))
    else $error("level rose without a write");
  a_single_hold: assert property (
    !fifo_control_reg[FIFO_EN_BIT] && tx_level <= 1 |=> tx_level <= 1)
    else $error("more than one byte held with fifo off");
  a_load_walk: assert property (
    s_wr_idle |-> s_load_start)
    else $error("load or start bit late");
  a_bit_period: assert property (
    $rose(tx_out) && one |-> low_q % n == 0 || low_q % n == n - 5'h01)
    else $error("low run not whole bits");
endmodule : utx_props
bind utx_top utx_props #(.DEPTH(DEPTH), .AW(AW)) utx_props_i (
  .clk(clk), .reset_n(reset_n), .hold_wr(hold_wr), .fifo_control_reg(fifo_control_reg),
  .irq_enable_reg(irq_enable_reg), .modem_control_reg(modem_control_reg),
  .baud_divisor_low(baud_divisor_low), .baud_divisor_high(baud_divisor_high),
  .baud_fraction_reg(baud_fraction_reg), .tx_out(tx_out), .line_status_reg(line_status_reg),
  .irq_status_reg(irq_status_reg), .irq_n(irq_n), .tx_level(tx_level));

// *** dv/utx_rx_model.sv ***
/*
  utx_rx_model: remote receiver on the serial line.
  Assumes the bench gives clocks per bit and the frame shape.
*/
`timescale 1ns/1ps
module utx_rx_model (
  input wire logic        clk,
  input wire logic        line,
  input wire logic [15:0] bit_clks,
  input wire logic [4:0]  shape,   // even, parity on, two stop, length
  output logic [7:0]      rx_byte,
  output logic            rx_bad,  // start, parity or stop fault
  output int              rx_cnt
);
  logic [7:0] d;
  logic       bad;
  // sample mid-bit on the falling clock, clear of line updates
  initial begin
    rx_cnt = 0;
    forever begin
      @(negedge line);
      repeat (bit_clks / 2) @(negedge clk);
      bad = line;
      d = 8'h00;
      for (int i = 0; i < shape[1:0] + 5; i++) begin
        repeat (bit_clks) @(negedge clk);
        d[i] = line;
      end
      if (shape[3]) begin
        repeat (bit_clks) @(negedge clk);
        bad |= line !== (^d ^ !shape[4]);
      end
      for (int i = 0; i < shape[2] + 1; i++) begin
        repeat (bit_clks) @(negedge clk);
        bad |= line !== 1'b1;
      end
      rx_byte = d;
      rx_bad = bad;
      rx_cnt++;
    end
  end
endmodule : utx_rx_model

// *** dv/testbench.sv ***
/*
  testbench: drives utx_top register levels and write strobe.
  Assumes utx_rx_model decodes the line and utx_props is bound.
*/
`timescale 1ns/1ps
module testbench
  import utx_pkg::*;
;
  logic        clk, reset_n, hold_wr, tx_out, irq_n, rx_bad;
  logic [7:0]  hold_data, fifo_ctl, irq_en, line_ctl, modem_ctl;  // register levels
  logic [7:0]  div_lo, div_hi, frac_ctl;                          // baud settings
  logic [7:0]  line_stat, irq_stat, rx_byte;                      // status, decoded byte
  logic [6:0]  lvl;
  logic [15:0] bclk;               // clocks per bit
  logic [7:0]  exp_q[$], got_q[$]; // sent, seen
  int          rx_cnt, n_errors = 0, total_checks = 0, cyc = 0;
  // line ctl, fraction, modem ctl, divisor, byte; last one uses the spare mode code
  logic [47:0] tbl[9] = '{48'h03_00_00_0001_a5, 48'h08_10_00_0001_5b,
    48'h1d_20_00_0001_2c, 48'h02_00_80_0001_7e, 48'h1b_08_00_0001_c3,
    48'h0f_14_00_0002_81, 48'h03_0f_00_0003_3c, 48'h03_20_00_0100_96,
    48'h03_30_00_0001_69};
  utx_top utx_top_i (.clk(clk), .reset_n(reset_n), .hold_wr(hold_wr),
    .tx_holding_reg(hold_data), .fifo_control_reg(fifo_ctl), .irq_enable_reg(irq_en),
    .line_control_reg(line_ctl), .modem_control_reg(modem_ctl), .baud_divisor_low(div_lo),
    .baud_divisor_high(div_hi), .baud_fraction_reg(frac_ctl), .tx_out(tx_out),
    .line_status_reg(line_stat), .irq_status_reg(irq_stat), .irq_n(irq_n),
    .tx_level(lvl));
  utx_rx_model utx_rx_model_i (.clk(clk), .line(tx_out), .bit_clks(bclk),
    .shape(line_ctl[4:0]), .rx_byte(rx_byte), .rx_bad(rx_bad), .rx_cnt(rx_cnt));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  // each decoded frame; the short wait lets byte and fault flag settle first
  always @(rx_cnt) begin
    #1;
    got_q.push_back(rx_byte);
    chk({7'h00, rx_bad}, 8'h00);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // line settings and the bit length they give
  task automatic cfg(input logic [47:0] r);
    int n;
    n = r[37:36] == MODE_8X ? 8 : r[37:36] == MODE_4X ? 4 : 16;
    {line_ctl, frac_ctl, modem_ctl, div_hi, div_lo} = r[47:8];
    bclk = 16'(n * (r[23:8] * 16 + r[35:32]) / 16 * (r[31] ? 4 : 1));
  endtask : cfg
  task automatic put(input logic [7:0] b, input logic keep);
    hold_wr = 1'b1;
    hold_data = b;
    if (keep)
      exp_q.push_back(b & (8'hff >> (3 - line_ctl[1:0])));
    step(1);
  endtask : put
  // wait for the line to go quiet, then compare
  task automatic drain();
    int k = 0;
    hold_wr = 1'b0;
    while ((got_q.size() < exp_q.size() || line_stat[6] !== 1'b1) && k < 20000) begin
      step(1);
      k++;
    end
    // a wait that runs out is a mismatch of its own
    chk(8'(k == 20000), 8'h00);
    chk(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[j])
      chk(got_q[j], exp_q[j]);
    chk(line_stat, 8'h60);
    exp_q.delete();
    got_q.delete();
  endtask : drain
  task automatic t_frames();
    fifo_ctl = 8'h01;
    foreach (tbl[r]) begin
      cfg(tbl[r]);
      step(1);
      put(tbl[r][7:0], 1'b1);
      drain();
    end
  endtask : t_frames
  // fill past full; last write dropped
  task automatic t_fill();
    cfg(tbl[0]);
    for (int i = 0; i < 66; i++)
      put(8'(i + 1), i < 65);
    chk({1'b0, lvl}, 8'h40);
    chk(line_stat, 8'h00);
    drain();
  endtask : t_fill
  task automatic t_single();
    fifo_ctl = 8'h00;
    step(1);
    put(8'h11, 1'b1);
    put(8'h22, 1'b0);
    hold_wr = 1'b0;
    step(2);
    chk(line_stat, 8'h20);
    put(8'h33, 1'b1);
    chk(line_stat, 8'h00);
    drain();
  endtask : t_single
  task automatic t_irq();
    step(2);
    chk(irq_stat, 8'h00);
    irq_en = 8'h02;
    step(2);
    chk({irq_stat[7:1], irq_n}, 8'h02);
    put(8'h44, 1'b1);
    chk({irq_stat[7:1], irq_n}, 8'h01);
    drain();
    chk(irq_stat, 8'h02);
  endtask : t_irq
  initial begin
    {hold_wr, hold_data, fifo_ctl, irq_en, line_ctl, modem_ctl, div_hi, frac_ctl} = '0;
    div_lo = 8'h01;
    bclk = 16'h0010;
    reset_n = 1'b0;
    step(3);
    reset_n = 1'b1;
    step(1);
    chk(line_stat, 8'h60);
    chk({tx_out, lvl}, 8'h80);
    t_frames();
    t_fill();
    t_single();
    t_irq();
    wrap_up();
  end
endmodule : testbench
